/* File: verilog/dbrc_pkg.sv */
// Package with constants and types for the debug break response control block.
`default_nettype none
package dbrc_pkg;
   // Debug control register layout, as seen through the link side scan path.
   localparam int             CTRL_W           = 6;
   localparam int             CTRL_MON_EN_BIT  = 4;
   localparam int             CTRL_DIS_BIT     = 5;
   localparam logic [5:0]     CTRL_RESET       = 6'h00;
   // Link command encodings (shifted in on the link clock).
   localparam int             CMD_W            = 2;
   localparam logic [1:0]     CMD_NOP          = 2'h0;
   localparam logic [1:0]     CMD_WR_CTRL      = 2'h1;
   localparam logic [1:0]     CMD_WR_MSG       = 2'h2;
   localparam logic [1:0]     CMD_RD_MSG       = 2'h3;
   localparam int             FRAME_W          = 34;
   localparam int             MSG_W            = 32;
   localparam logic [31:0]    MSG_RESET        = 32'h0000_0000;
   localparam logic [5:0]     CNT_RESET        = 6'h00;
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_ABORT = 3'b010,
      ST_HALT  = 3'b100
   } dbrc_state_t;
endpackage : dbrc_pkg
`default_nettype wire

/* File: verilog/dbrc_top.sv */
// Break response control with a serial debugger link and a message channel.
`timescale 1ns/100ps
`default_nettype none
module dbrc_top (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        bp_match,
   input  wire logic        wp_match,
   input  wire logic        mem_prefetch_abort,
   input  wire logic        mem_data_abort,
   input  wire logic        irq_req,
   input  wire logic        halt_release,
   input  wire logic        tgt_msg_wr,
   input  wire logic [31:0] tgt_msg_wdata,
   input  wire logic        tgt_msg_rd,
   input  wire logic        link_clk,
   input  wire logic        link_rst_n,
   input  wire logic        link_tdi,
   input  wire logic        link_frame,
   output logic             link_tdo,
   output logic             take_prefetch_abort,
   output logic             take_data_abort,
   output logic             debug_halt,
   output logic             irq_to_core,
   output logic             abort_cause_register,
   output logic             match_enable,
   output logic             monitor_enable,
   output logic             h2t_full,
   output logic [31:0]      h2t_data,
   output logic             t2h_full
);
   // Link clock domain: frames shift in and the target word shifts out.
   logic [33:0] sh_reg, sh_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [5:0]  lctrl_reg, lctrl_next;
   logic        ltog_c_reg, ltog_c_next;
   logic [31:0] lmsg_reg, lmsg_next;
   logic        ltog_m_reg, ltog_m_next;
   logic        ltog_r_reg, ltog_r_next;
   logic        tdo_reg, tdo_next;
   logic [2:0]  t2h_sync;
   logic [31:0] t2h_word_l;
   always_comb begin
      sh_next     = sh_reg;
      cnt_next    = cnt_reg;
      lctrl_next  = lctrl_reg;
      ltog_c_next = ltog_c_reg;
      lmsg_next   = lmsg_reg;
      ltog_m_next = ltog_m_reg;
      ltog_r_next = ltog_r_reg;
      tdo_next    = tdo_reg;
      if (link_frame) begin
         sh_next  = {link_tdi, sh_reg[33:1]};
         cnt_next = cnt_reg + 6'h01;
         // Out-shift of the target-to-host word, bit 32 flags it valid.
         if (cnt_reg < 6'(dbrc_pkg::MSG_W)) begin
            tdo_next = t2h_word_l[cnt_reg[4:0]];
         end else begin
            tdo_next = t2h_sync[2];
         end
         if (cnt_reg == 6'(dbrc_pkg::FRAME_W - 1)) begin
            cnt_next = dbrc_pkg::CNT_RESET;
            // The top command bit arrives with the last edge of the frame.
            case ({link_tdi, sh_reg[33]})
               dbrc_pkg::CMD_WR_CTRL: begin
                  lctrl_next  = sh_reg[6:1];
                  ltog_c_next = ~ltog_c_reg;
               end
               dbrc_pkg::CMD_WR_MSG: begin
                  lmsg_next   = sh_reg[32:1];
                  ltog_m_next = ~ltog_m_reg;
               end
               dbrc_pkg::CMD_RD_MSG: begin
                  ltog_r_next = ~ltog_r_reg;
               end
               default: ;
            endcase
         end
      end else begin
         cnt_next = dbrc_pkg::CNT_RESET;
      end
   end
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sh_reg     <= 34'h0_0000_0000;
         cnt_reg    <= dbrc_pkg::CNT_RESET;
         lctrl_reg  <= dbrc_pkg::CTRL_RESET;
         ltog_c_reg <= 1'b0;
         lmsg_reg   <= dbrc_pkg::MSG_RESET;
         ltog_m_reg <= 1'b0;
         ltog_r_reg <= 1'b0;
         tdo_reg    <= 1'b0;
      end else begin
         sh_reg     <= sh_next;
         cnt_reg    <= cnt_next;
         lctrl_reg  <= lctrl_next;
         ltog_c_reg <= ltog_c_next;
         lmsg_reg   <= lmsg_next;
         ltog_m_reg <= ltog_m_next;
         ltog_r_reg <= ltog_r_next;
         tdo_reg    <= tdo_next;
      end
   end
   assign link_tdo = tdo_reg;
   // Crossings between the link and core clock domains.
   // Core-domain full flag and its held word cross to the link as a level; the
   // word is stable whenever the flag is seen set.
   logic        t2h_full_reg;
   logic [31:0] t2h_word_reg;
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         t2h_sync <= 3'b000;
      end else begin
         t2h_sync <= {t2h_sync[1], t2h_sync[0], t2h_full_reg};
      end
   end
   assign t2h_word_l = t2h_word_reg;
   logic [2:0] sc_c, sc_m, sc_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sc_c <= 3'b000;
         sc_m <= 3'b000;
         sc_r <= 3'b000;
      end else begin
         sc_c <= {sc_c[1], sc_c[0], ltog_c_reg};
         sc_m <= {sc_m[1], sc_m[0], ltog_m_reg};
         sc_r <= {sc_r[1], sc_r[0], ltog_r_reg};
      end
   end
   wire ev_ctrl = sc_c[2] ^ sc_c[1];
   wire ev_msg  = sc_m[2] ^ sc_m[1];
   wire ev_rd   = sc_r[2] ^ sc_r[1];
   // Core clock domain.
   dbrc_pkg::dbrc_state_t st_reg, st_next;
   logic [5:0]  ctrl_reg, ctrl_next;
   logic        pa_reg, pa_next, da_reg, da_next, cause_reg, cause_next;
   logic        irq_reg, irq_next;
   logic        h2t_full_reg, h2t_full_next, t2h_full_next;
   logic [31:0] h2t_reg, h2t_next, t2h_word_next;
   logic        mon, en, dbg_hit;
   logic        men_reg, men_next;
   always_comb begin
      ctrl_next     = ctrl_reg;
      st_next       = st_reg;
      pa_next       = 1'b0;
      da_next       = 1'b0;
      cause_next    = cause_reg;
      h2t_full_next = h2t_full_reg;
      h2t_next      = h2t_reg;
      t2h_full_next = t2h_full_reg;
      t2h_word_next = t2h_word_reg;
      if (ev_ctrl) begin
         ctrl_next = lctrl_reg;
      end
      // Registered copy of the enable so the output comes from a flip-flop.
      men_next = !ctrl_next[dbrc_pkg::CTRL_DIS_BIT];
      mon     = ctrl_reg[dbrc_pkg::CTRL_MON_EN_BIT];
      en      = !ctrl_reg[dbrc_pkg::CTRL_DIS_BIT];
      dbg_hit = en && (bp_match || wp_match);
      case (st_reg)
         dbrc_pkg::ST_RUN: begin
            if (dbg_hit && !mon) begin
               st_next = dbrc_pkg::ST_HALT;
            end else if (dbg_hit && mon) begin
               pa_next    = bp_match;
               da_next    = wp_match;
               cause_next = 1'b1;
            end else if (mem_prefetch_abort || mem_data_abort) begin
               pa_next    = mem_prefetch_abort;
               da_next    = mem_data_abort;
               cause_next = 1'b0;
            end
         end
         dbrc_pkg::ST_HALT: begin
            if (halt_release) begin
               st_next = dbrc_pkg::ST_RUN;
            end
         end
         default: st_next = dbrc_pkg::ST_RUN;
      endcase
      irq_next = irq_req && (st_next != dbrc_pkg::ST_HALT);
      // Host-to-target word: a fresh arrival wins over a same-cycle read.
      if (ev_msg) begin
         h2t_next      = lmsg_reg;
         h2t_full_next = 1'b1;
      end else if (tgt_msg_rd) begin
         h2t_full_next = 1'b0;
      end
      if (ev_rd) begin
         t2h_full_next = 1'b0;
      end
      if (tgt_msg_wr && !t2h_full_reg) begin
         t2h_word_next = tgt_msg_wdata;
         t2h_full_next = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg       <= dbrc_pkg::ST_RUN;
         ctrl_reg     <= dbrc_pkg::CTRL_RESET;
         men_reg      <= 1'b1;
         pa_reg       <= 1'b0;
         da_reg       <= 1'b0;
         cause_reg    <= 1'b0;
         irq_reg      <= 1'b0;
         h2t_full_reg <= 1'b0;
         h2t_reg      <= dbrc_pkg::MSG_RESET;
         t2h_full_reg <= 1'b0;
         t2h_word_reg <= dbrc_pkg::MSG_RESET;
      end else begin
         st_reg       <= st_next;
         ctrl_reg     <= ctrl_next;
         men_reg      <= men_next;
         pa_reg       <= pa_next;
         da_reg       <= da_next;
         cause_reg    <= cause_next;
         irq_reg      <= irq_next;
         h2t_full_reg <= h2t_full_next;
         h2t_reg      <= h2t_next;
         t2h_full_reg <= t2h_full_next;
         t2h_word_reg <= t2h_word_next;
      end
   end
   assign take_prefetch_abort  = pa_reg;
   assign take_data_abort      = da_reg;
   assign debug_halt           = st_reg[2];
   assign irq_to_core          = irq_reg;
   assign abort_cause_register = cause_reg;
   assign match_enable         = men_reg;
   assign monitor_enable       = ctrl_reg[dbrc_pkg::CTRL_MON_EN_BIT];
   assign h2t_full             = h2t_full_reg;
   assign h2t_data             = h2t_reg;
   assign t2h_full             = t2h_full_reg;
endmodule : dbrc_top
`default_nettype wire

/* File: sim/dbrc_asserts.sv */
// Checker of the break response timing at the block's top ports.
`timescale 1ns/100ps
`default_nettype none
module dbrc_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bp_match,
   input wire logic wp_match,
   input wire logic mem_prefetch_abort,
   input wire logic mem_data_abort,
   input wire logic irq_req,
   input wire logic halt_release,
   input wire logic take_prefetch_abort,
   input wire logic take_data_abort,
   input wire logic debug_halt,
   input wire logic irq_to_core,
   input wire logic abort_cause_register,
   input wire logic match_enable,
   input wire logic monitor_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic hit;
   assign hit = (bp_match | wp_match) & match_enable & !debug_halt;
   a_mon_bp_abort: assert property (
      hit && monitor_enable && bp_match |=> take_prefetch_abort)
      else $error("missing prefetch abort");
   a_mon_wp_abort: assert property (
      hit && monitor_enable && wp_match |=> take_data_abort)
      else $error("missing data abort");
   a_halt_entry: assert property (hit && !monitor_enable |=> debug_halt) else $error("no halt");
   a_halt_holds: assert property (
      debug_halt && !halt_release |=> debug_halt)
      else $error("halt dropped");
   a_dis_quiet: assert property (
      !match_enable && !mem_prefetch_abort && !mem_data_abort
      |=> !take_prefetch_abort && !take_data_abort && !$rose(debug_halt))
      else $error("match while disabled");
   a_cause_dbg: assert property (
      hit && monitor_enable |=> abort_cause_register)
      else $error("cause not debug");
   a_cause_real: assert property (
      !debug_halt && !hit && mem_data_abort |=> take_data_abort && !abort_cause_register)
      else $error("cause not real");
   a_irq_pass: assert property (
      !debug_halt ##1 !debug_halt |-> irq_to_core == $past(irq_req))
      else $error("interrupt not passed");
   c_halt: cover property (hit && !monitor_enable);
   c_dbg_abort: cover property (take_prefetch_abort && abort_cause_register);
   c_real_abort: cover property (take_data_abort && !abort_cause_register);
endmodule : dbrc_chk
bind dbrc_top dbrc_chk u_chk (.*);
`default_nettype wire

/* File: sim/dbrc_host.sv */
// Host debugger model that shifts command frames into the serial link.
`timescale 1ns/100ps
`default_nettype none
module dbrc_host (
   output logic      link_clk,
   output logic      link_tdi,
   output logic      link_frame,
   input  wire logic link_tdo
);
   // Bits seen on the serial output during the latest frame, in shift order.
   logic [33:0] rx;
   initial begin
      link_clk = 1'h0;
      link_frame = 1'h0;
      link_tdi = 1'h0;
      repeat (2) begin
         #24 link_clk = 1'h1;
         #24 link_clk = 1'h0;
      end
   end
   // The clock runs inside a frame, and twice idle at start; payload goes LSB first, command last.
   task automatic send(input logic [1:0] cmd, input logic [31:0] pay);
      logic [33:0] f;
      f = {cmd, pay};
      link_frame = 1'h1;
      for (int k = 0; k < 34; k++) begin
         link_tdi = f[k];
         #24 link_clk = 1'h1;
         #24 link_clk = 1'h0;
         rx[k] = link_tdo;
      end
      link_frame = 1'h0;
      link_tdi = ~link_tdi;
   endtask : send
endmodule : dbrc_host
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the break response control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk, reset_n, link_rst_n, bp_match, wp_match, mem_prefetch_abort;
   logic        mem_data_abort, irq_req, halt_release, tgt_msg_wr, tgt_msg_rd;
   logic [31:0] tgt_msg_wdata, h2t_data;
   logic        link_clk, link_tdi, link_frame, link_tdo, take_prefetch_abort;
   logic        take_data_abort, debug_halt, irq_to_core, abort_cause_register;
   logic        match_enable, monitor_enable, h2t_full, t2h_full;
   int          err_total, check_count;
   assign link_rst_n = reset_n;
   dbrc_top DUT (.*);
   dbrc_host host (
      .link_clk   (link_clk),
      .link_tdi   (link_tdi),
      .link_frame (link_frame),
      .link_tdo   (link_tdo)
   );
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task cyc;
      @(posedge clk);
      #1;
   endtask : cyc
   task chk(input logic [31:0] exp, input logic [31:0] got, input string n);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", n, exp, got);
      end
   endtask : chk
   task wr(input logic [1:0] c, input logic [31:0] p);
      host.send(c, p);
      repeat (10) cyc();
   endtask : wr
   task give_verdict;
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task t_halt;
      bp_match = 1'h1;
      cyc();
      bp_match = 1'h0;
      irq_req = 1'h1;
      chk(1'h1, debug_halt, "debug_halt");
      chk(1'h0, take_prefetch_abort, "take_prefetch_abort");
      repeat (2) cyc();
      chk(1'h1, debug_halt, "debug_halt");
      chk(1'h0, irq_to_core, "irq_to_core");
      halt_release = 1'h1;
      cyc();
      chk(1'h1, irq_to_core, "irq_to_core");
      halt_release = 1'h0;
      irq_req = 1'h0;
      cyc();
      chk(1'h0, debug_halt, "debug_halt");
   endtask : t_halt
   task t_monitor;
      wr(dbrc_pkg::CMD_WR_CTRL, 32'h0000_0010);
      chk(1'h1, monitor_enable, "monitor_enable");
      irq_req = 1'h1;
      bp_match = 1'h1;
      cyc();
      bp_match = 1'h0;
      mem_data_abort = 1'h1;
      chk(1'h1, take_prefetch_abort, "take_prefetch_abort");
      chk(1'h1, abort_cause_register, "abort_cause_register");
      chk(1'h0, debug_halt, "debug_halt");
      cyc();
      mem_data_abort = 1'h0;
      wp_match = 1'h1;
      chk(1'h1, take_data_abort, "take_data_abort");
      chk(1'h0, abort_cause_register, "abort_cause_register");
      chk(1'h1, irq_to_core, "irq_to_core");
      cyc();
      wp_match = 1'h0;
      irq_req = 1'h0;
      chk(1'h1, take_data_abort, "take_data_abort");
      chk(1'h1, abort_cause_register, "abort_cause_register");
   endtask : t_monitor
   task t_disable;
      wr(dbrc_pkg::CMD_WR_CTRL, 32'h0000_0030);
      chk(1'h0, match_enable, "match_enable");
      bp_match = 1'h1;
      cyc();
      bp_match = 1'h0;
      chk(1'h0, take_prefetch_abort, "take_prefetch_abort");
      wr(dbrc_pkg::CMD_WR_CTRL, 32'h0000_0010);
      chk(1'h1, match_enable, "match_enable");
      bp_match = 1'h1;
      cyc();
      bp_match = 1'h0;
      chk(1'h1, take_prefetch_abort, "take_prefetch_abort");
   endtask : t_disable
   task t_msg;
      wr(dbrc_pkg::CMD_WR_MSG, 32'hA5C3_1E0F);
      chk(1'h1, h2t_full, "h2t_full");
      chk(32'hA5C3_1E0F, h2t_data, "h2t_data");
      tgt_msg_rd = 1'h1;
      cyc();
      tgt_msg_rd = 1'h0;
      tgt_msg_wr = 1'h1;
      tgt_msg_wdata = 32'h5A3C_E1F0;
      cyc();
      tgt_msg_wr = 1'h0;
      chk(1'h0, h2t_full, "h2t_full");
      chk(1'h1, t2h_full, "t2h_full");
      wr(dbrc_pkg::CMD_RD_MSG, 32'h0000_0000);
      chk(32'h5A3C_E1F0, host.rx[31:0], "link_tdo word");
      chk(1'h1, host.rx[32], "link_tdo valid");
      chk(1'h0, t2h_full, "t2h_full");
   endtask : t_msg
   initial begin
      {bp_match, wp_match, mem_prefetch_abort, mem_data_abort, irq_req} = '0;
      {halt_release, tgt_msg_wr, tgt_msg_rd, tgt_msg_wdata} = '0;
      reset_n = 1'h0;
      err_total = 0;
      check_count = 0;
      repeat (16) @(posedge clk);
      #1 reset_n = 1'h1;
      cyc();
      t_halt();
      t_monitor();
      t_disable();
      t_msg();
      give_verdict();
   end
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
